// ---- inc/lapb_pkg.sv ----
// Constants and types shared by the LAPB link framer
`default_nettype none
package lapb_pkg;
	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam logic [7:0]  FLAG_OCTET       = 8'h7e;
	localparam int          MAX_BLOCK_OCTETS = 128;
	localparam int          HDR_OCTETS       = 2;
	localparam int          MIN_FRAME_BITS   = 32;
	localparam int          RX_BUF_OCTETS    = 132;
	localparam logic [10:0] RX_MAX_BITS      = 11'h420;
	localparam logic [2:0]  STUFF_ONES       = 3'h5;
	localparam logic [2:0]  FLAG_DELAY       = 3'h7;
	// ------------------------------------------------------------
	// Station addresses as printed, most significant bit first
	// ------------------------------------------------------------
	localparam logic [7:0]  DEF_LOCAL_ADDR   = 8'hc0;
	localparam logic [7:0]  DEF_PEER_ADDR    = 8'h80;
	// ------------------------------------------------------------
	// Control field codes, poll/final bit cleared
	// ------------------------------------------------------------
	localparam logic [7:0]  PF_MASK          = 8'h10;
	localparam logic [7:0]  S_RR             = 8'h01;
	localparam logic [7:0]  S_RNR            = 8'h05;
	localparam logic [7:0]  S_REJ            = 8'h09;
	localparam logic [7:0]  C_SABM           = 8'h2f;
	localparam logic [7:0]  C_UA             = 8'h63;
	localparam logic [7:0]  C_DISC           = 8'h43;
	localparam logic [7:0]  C_DM             = 8'h0f;
	localparam logic [7:0]  C_FRMR           = 8'h87;
	// ------------------------------------------------------------
	// Frame check sequence, bit-reflected CRC-16
	// ------------------------------------------------------------
	localparam logic [15:0] CRC_POLY         = 16'h8408;
	localparam logic [15:0] CRC_INIT         = 16'hffff;
	localparam logic [15:0] CRC_RESIDUE      = 16'hf0b8;
	typedef enum logic [3:0] {
		L_DOWN  = 4'b0001,
		L_SETUP = 4'b0010,
		L_UP    = 4'b0100,
		L_CLOSE = 4'b1000
	} link_type;
	typedef enum logic [1:0] {
		T_FLAG = 2'b01,
		T_BODY = 2'b10
	} tx_type;
endpackage
`default_nettype wire

// ---- core/lapb_link_framer.sv ----
// LAPB combined station: framing, stuffing, FCS and link procedure
// Functional notes
// - host blocks hold 1 to 128 octets
// - frames open and close with 01111110
// - one flag may close and open frames
// - empty information field is legal
// - address and control are one octet
// - command names destination, response names sender
// - basic control field, modulo 8 counts
// - 16-bit FCS before closing flag
// - information length counted in bits
// - commands may start at any time
// - station sends and takes commands, responses
// - information frames are commands only
// - receive ready and not ready supported
// - reject command answered by reject
// - set-mode gets acknowledge, disconnect gets DM
// - poll set demands final set
// - exceptions reported and recovered
// - link setup and disconnect per procedure
`default_nettype none
module lapb_link_framer
	import lapb_pkg::*;
#(
	parameter int MAX_BLOCK = MAX_BLOCK_OCTETS
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic [15:0] BIT_DIV,
	input  wire logic        USE_CFG_ADDR,
	input  wire logic [7:0]  LOCAL_ADDR,
	input  wire logic [7:0]  PEER_ADDR,
	input  wire logic        LINK_OPEN,
	input  wire logic        LINK_CLOSE,
	output logic             LINK_UP,
	input  wire logic [7:0]  TX_DATA,
	input  wire logic        TX_VALID,
	input  wire logic        TX_LAST,
	output logic             TX_READY,
	output logic             TXD,
	output logic             TX_BIT_STROBE,
	input  wire logic        RXD,
	input  wire logic        RX_BIT_VALID,
	output logic [7:0]       RX_DATA,
	output logic             RX_VALID,
	output logic             RX_LAST,
	output logic [3:0]       RX_LAST_BITS,
	input  wire logic        RX_READY
);
	if (MAX_BLOCK < 1 || MAX_BLOCK > MAX_BLOCK_OCTETS) begin : g_chk
		$error("MAX_BLOCK out of range");
	end

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		crc_step = (c[0] ^ b) ? ({1'b0, c[15:1]} ^ CRC_POLY) : {1'b0, c[15:1]};
	endfunction

	logic [7:0]  tbuf [MAX_BLOCK];
	logic [7:0]  rbuf [RX_BUF_OCTETS];
	logic [15:0] tdiv, next_tdiv;
	tx_type      tstate, next_tstate;
	logic [7:0]  tsh, next_tsh, tidx, next_tidx, t_len, next_t_len;
	logic [7:0]  t_addr, next_t_addr, t_ctrl, next_t_ctrl;
	logic [2:0]  tbit, next_tbit, tones, next_tones;
	logic        tstuff, next_tstuff, txd, next_txd, tstrobe, next_tstrobe;
	logic [15:0] tcrc, next_tcrc, tfcs, next_tfcs;
	logic        tick, start, took_resp, took_cmd, took_i;
	logic [7:0]  sel_addr, sel_ctrl, sel_len, loc_addr, peer_addr;
	logic [7:0]  rsh, next_rsh, r_addr, next_r_addr, r_ctrl, next_r_ctrl, racc, next_racc;
	logic [2:0]  rones, next_rones, dcnt, next_dcnt;
	logic [6:0]  dly, next_dly;
	logic [10:0] nbits, next_nbits;
	logic [15:0] rcrc, next_rcrc;
	logic        in_frame, next_in_frame, rover, next_rover, frame_good;
	logic        rb_we;
	logic [7:0]  rb_wa, rb_wd;
	link_type    lstate, next_lstate;
	logic        sabm_due, next_sabm_due, disc_due, next_disc_due;
	logic        resp_pend, next_resp_pend, i_sent, next_i_sent, peer_busy, next_peer_busy;
	logic [7:0]  resp_ctrl, next_resp_ctrl, t_cnt, next_t_cnt, t_wr, next_t_wr;
	logic [2:0]  vs, next_vs, vr, next_vr;
	logic        t_loaded, next_t_loaded, deliv, next_deliv, tb_we;
	logic [7:0]  d_idx, next_d_idx, d_last, next_d_last;
	logic [3:0]  d_lbits, next_d_lbits, next_rx_lbits;
	logic [7:0]  next_rx_data;
	logic        next_rx_valid, next_rx_last;
	logic        is_cmd, is_rsp;
	logic [7:0]  pf_f;
	logic [10:0] ib;
	logic [7:0]  ib_oct;

	assign loc_addr  = USE_CFG_ADDR ? LOCAL_ADDR : DEF_LOCAL_ADDR;
	assign peer_addr = USE_CFG_ADDR ? PEER_ADDR : DEF_PEER_ADDR;
	assign tick      = (tdiv == 16'h0000);
	assign TXD       = txd;
	assign TX_BIT_STROBE = tstrobe;
	assign TX_READY  = !t_loaded;
	assign LINK_UP   = (lstate == L_UP);

	// ------------------------------------------------------------
	// Transmitter: bit timing, stuffing and frame assembly
	// ------------------------------------------------------------
	always_comb begin
		next_tdiv = tick ? ((BIT_DIV == 16'h0000) ? 16'h0000 : BIT_DIV - 16'h0001)
		                 : tdiv - 16'h0001;
		next_tstate = tstate;
		{next_tsh, next_tidx, next_t_len} = {tsh, tidx, t_len};
		{next_t_addr, next_t_ctrl, next_tbit, next_tones} = {t_addr, t_ctrl, tbit, tones};
		{next_tstuff, next_txd, next_tcrc, next_tfcs} = {tstuff, txd, tcrc, tfcs};
		next_tstrobe = tick;
		start = 1'b0;
		// Responses go first so a poll is never starved by queued data
		took_resp = 1'b0;
		took_cmd = 1'b0;
		took_i = 1'b0;
		sel_addr = peer_addr;
		sel_len = 8'h00;
		sel_ctrl = 8'h00;
		if (resp_pend) begin
			sel_addr = loc_addr;
			sel_ctrl = (resp_ctrl[1:0] == 2'b01) ? {vr, resp_ctrl[4:0]} : resp_ctrl;
		end else if (sabm_due) begin
			sel_ctrl = C_SABM | PF_MASK;
		end else if (disc_due) begin
			sel_ctrl = C_DISC | PF_MASK;
		end else begin
			sel_ctrl = {vr, 1'b0, vs, 1'b0};
			sel_len = t_cnt;
		end
		if (tick && tstuff) begin
			next_txd = 1'b0;
			next_tstuff = 1'b0;
			next_tones = 3'h0;
		end else if (tick) begin
			next_txd = tsh[0];
			next_tsh = {1'b0, tsh[7:1]};
			next_tbit = tbit + 3'h1;
			if (tstate == T_BODY) begin
				next_tcrc = crc_step(tcrc, tsh[0]);
				next_tones = tsh[0] ? tones + 3'h1 : 3'h0;
				if (tsh[0] && tones == STUFF_ONES - 3'h1) begin
					next_tstuff = 1'b1;
				end
			end
			if (tbit == 3'h7) begin
				if (tstate == T_FLAG) begin
					if (resp_pend || sabm_due || disc_due
					    || (lstate == L_UP && t_loaded && !i_sent && !peer_busy)) begin
						start = 1'b1;
						took_resp = resp_pend;
						took_cmd = !resp_pend && (sabm_due || disc_due);
						took_i = !resp_pend && !sabm_due && !disc_due;
						next_tstate = T_BODY;
						next_tsh = sel_addr;
						next_t_ctrl = sel_ctrl;
						next_t_len = sel_len;
						next_tidx = 8'h01;
						next_tcrc = CRC_INIT;
						next_tones = 3'h0;
					end else begin
						next_tsh = FLAG_OCTET;
					end
				end else begin
					next_tidx = tidx + 8'h01;
					if (tidx == 8'h01) begin
						next_tsh = t_ctrl;
					end else if (tidx < t_len + 8'h02) begin
						next_tsh = tbuf[7'(tidx - 8'h02)];
					end else if (tidx == t_len + 8'h02) begin
						next_tfcs = ~next_tcrc;
						next_tsh = ~next_tcrc[7:0];
					end else if (tidx == t_len + 8'h03) begin
						next_tsh = tfcs[15:8];
					end else begin
						next_tsh = FLAG_OCTET;
						next_tstate = T_FLAG;
						next_tones = 3'h0;
					end
				end
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			tdiv <= 16'h0000;
			tstate <= T_FLAG;
			tsh <= FLAG_OCTET;
			{tidx, t_len, t_addr, t_ctrl, tbit, tones} <= '0;
			{tstuff, tstrobe} <= 2'b00;
			txd <= 1'b1;
			{tcrc, tfcs} <= {CRC_INIT, CRC_INIT};
		end else begin
			tdiv <= next_tdiv;
			tstate <= next_tstate;
			{tsh, tidx, t_len} <= {next_tsh, next_tidx, next_t_len};
			{t_addr, t_ctrl, tbit, tones} <= {next_t_addr, next_t_ctrl, next_tbit, next_tones};
			{tstuff, txd, tstrobe} <= {next_tstuff, next_txd, next_tstrobe};
			{tcrc, tfcs} <= {next_tcrc, next_tfcs};
		end
		if (tb_we) begin
			tbuf[t_wr[6:0]] <= TX_DATA;
		end
	end

	// ------------------------------------------------------------
	// Receiver: flag hunt, destuffing, FCS check
	// ------------------------------------------------------------
	// A seven-bit delay keeps the leading bits of a closing flag out of the frame
	always_comb begin
		{next_rsh, next_rones, next_dcnt, next_dly} = {rsh, rones, dcnt, dly};
		{next_nbits, next_rcrc, next_in_frame, next_rover} = {nbits, rcrc, in_frame, rover};
		{next_racc, next_r_addr, next_r_ctrl} = {racc, r_addr, r_ctrl};
		frame_good = 1'b0;
		rb_we = 1'b0;
		rb_wa = nbits[10:3];
		rb_wd = {dly[0], racc[7:1]};
		if (RX_BIT_VALID) begin
			next_rsh = {RXD, rsh[7:1]};
			if ({RXD, rsh[7:1]} == FLAG_OCTET) begin
				frame_good = in_frame && !rover && nbits >= 11'(MIN_FRAME_BITS)
				             && rcrc == CRC_RESIDUE;
				next_in_frame = 1'b1;
				{next_nbits, next_dcnt, next_rones, next_rover} = '0;
				next_rcrc = CRC_INIT;
			end else if (RXD && rones == 3'h6) begin
				next_in_frame = 1'b0;
				next_rones = 3'h7;
			end else if (!RXD && rones == STUFF_ONES) begin
				next_rones = 3'h0;
			end else begin
				next_rones = RXD ? ((rones == 3'h7) ? rones : rones + 3'h1) : 3'h0;
				next_dly = {RXD, dly[6:1]};
				if (dcnt != FLAG_DELAY) begin
					next_dcnt = dcnt + 3'h1;
				end else if (in_frame && nbits == RX_MAX_BITS) begin
					next_rover = 1'b1;
				end else if (in_frame) begin
					next_rcrc = crc_step(rcrc, dly[0]);
					next_racc = {dly[0], racc[7:1]};
					next_nbits = nbits + 11'h001;
					if (nbits[2:0] == 3'h7) begin
						rb_we = !deliv && nbits[10:3] >= 8'(HDR_OCTETS);
						if (nbits[10:3] == 8'h00) next_r_addr = rb_wd;
						if (nbits[10:3] == 8'h01) next_r_ctrl = rb_wd;
					end
				end
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			{rsh, rones, dcnt, dly, nbits, in_frame, rover, racc, r_addr, r_ctrl} <= '0;
			rcrc <= CRC_INIT;
		end else begin
			{rsh, rones, dcnt, dly} <= {next_rsh, next_rones, next_dcnt, next_dly};
			{nbits, rcrc, in_frame, rover} <= {next_nbits, next_rcrc, next_in_frame, next_rover};
			{racc, r_addr, r_ctrl} <= {next_racc, next_r_addr, next_r_ctrl};
		end
		if (rb_we) begin
			rbuf[rb_wa] <= rb_wd;
		end
	end

	// ------------------------------------------------------------
	// Link procedure, host block intake and delivery
	// ------------------------------------------------------------
	always_comb begin
		next_lstate = lstate;
		{next_sabm_due, next_disc_due} = {sabm_due, disc_due};
		{next_resp_pend, next_resp_ctrl, next_i_sent} = {resp_pend, resp_ctrl, i_sent};
		{next_peer_busy, next_vs, next_vr} = {peer_busy, vs, vr};
		{next_t_loaded, next_t_cnt, next_t_wr} = {t_loaded, t_cnt, t_wr};
		{next_deliv, next_d_idx, next_d_last, next_d_lbits} = {deliv, d_idx, d_last, d_lbits};
		{next_rx_data, next_rx_valid, next_rx_last, next_rx_lbits} =
			{RX_DATA, RX_VALID, RX_LAST, RX_LAST_BITS};
		is_cmd = (r_addr == loc_addr);
		is_rsp = (r_addr == peer_addr);
		pf_f = (is_cmd && r_ctrl[4]) ? PF_MASK : 8'h00;
		ib = nbits - 11'(MIN_FRAME_BITS);
		ib_oct = ib[10:3] + {7'h00, ib[2:0] != 3'h0};
		tb_we = TX_VALID && !t_loaded;
		if (tb_we) begin
			if (TX_LAST || t_wr == 8'(MAX_BLOCK - 1)) begin
				next_t_loaded = 1'b1;
				next_t_cnt = t_wr + 8'h01;
				next_t_wr = 8'h00;
			end else begin
				next_t_wr = t_wr + 8'h01;
			end
		end
		// A request arriving as the previous one is taken must not be lost
		if (took_cmd) {next_sabm_due, next_disc_due} = 2'b00;
		if (LINK_OPEN) begin
			{next_sabm_due, next_disc_due} = 2'b10;
			next_lstate = L_SETUP;
		end else if (LINK_CLOSE) begin
			{next_sabm_due, next_disc_due} = 2'b01;
			next_lstate = L_CLOSE;
		end
		if (took_resp) next_resp_pend = 1'b0;
		if (took_i) next_i_sent = 1'b1;
		if (deliv && (!RX_VALID || RX_READY)) begin
			next_rx_data = rbuf[d_idx];
			next_rx_valid = 1'b1;
			next_rx_last = (d_idx == d_last);
			next_rx_lbits = (d_idx == d_last) ? d_lbits : 4'h8;
			next_d_idx = d_idx + 8'h01;
			next_deliv = (d_idx != d_last);
		end else if (RX_READY) begin
			next_rx_valid = 1'b0;
		end
		if (frame_good && (is_cmd || is_rsp) && lstate == L_UP && r_ctrl[1:0] != 2'b11
		    && i_sent && r_ctrl[7:5] == vs + 3'h1) begin
			{next_vs, next_i_sent, next_t_loaded} = {vs + 3'h1, 2'b00};
		end
		// Hardware events beat the transmitter's clear of the pending response
		if (frame_good && (is_cmd || is_rsp)) begin
			if (!r_ctrl[0]) begin
				if (is_rsp) begin
					{next_resp_pend, next_resp_ctrl} = {1'b1, C_FRMR};
				end else if (lstate != L_UP) begin
					if (r_ctrl[4]) {next_resp_pend, next_resp_ctrl} = {1'b1, C_DM | pf_f};
				end else if (deliv) begin
					{next_resp_pend, next_resp_ctrl} = {1'b1, S_RNR | pf_f};
				end else if (r_ctrl[3:1] == vr) begin
					{next_resp_pend, next_resp_ctrl} = {1'b1, S_RR | pf_f};
					next_vr = vr + 3'h1;
					next_deliv = (ib != 11'h000);
					next_d_idx = 8'(HDR_OCTETS);
					next_d_last = 8'(HDR_OCTETS) + ib_oct - 8'h01;
					next_d_lbits = (ib[2:0] == 3'h0) ? 4'h8 : {1'b0, ib[2:0]};
				end else begin
					{next_resp_pend, next_resp_ctrl} = {1'b1, S_REJ | pf_f};
				end
			end else if (!r_ctrl[1]) begin
				if (lstate == L_UP) begin
					next_peer_busy = (r_ctrl[3:2] == 2'b01);
					if (r_ctrl[3:2] == 2'b10 && r_ctrl[7:5] == vs) next_i_sent = 1'b0;
					if (is_cmd && r_ctrl[4]) begin
						next_resp_pend = 1'b1;
						next_resp_ctrl = (r_ctrl[3:2] == 2'b10) ? (S_REJ | pf_f)
						                : ((deliv ? S_RNR : S_RR) | pf_f);
					end
				end else if (is_cmd && r_ctrl[4]) begin
					{next_resp_pend, next_resp_ctrl} = {1'b1, C_DM | pf_f};
				end
			end else begin
				unique case (r_ctrl & ~PF_MASK)
					C_SABM: if (is_cmd) begin
						{next_resp_pend, next_resp_ctrl} = {1'b1, C_UA | pf_f};
						next_lstate = L_UP;
						{next_vs, next_vr} = 6'h00;
						{next_i_sent, next_peer_busy} = 2'b00;
					end
					C_DISC: if (is_cmd) begin
						{next_resp_pend, next_resp_ctrl} = {1'b1, C_DM | pf_f};
						next_lstate = L_DOWN;
					end
					C_UA: if (is_rsp && lstate == L_SETUP) begin
						next_lstate = L_UP;
						{next_vs, next_vr, next_i_sent} = 7'h00;
					end else if (is_rsp && lstate == L_CLOSE) begin
						next_lstate = L_DOWN;
					end
					C_DM: if (is_rsp) next_lstate = L_DOWN;
					C_FRMR: if (is_rsp) begin
						next_sabm_due = 1'b1;
						next_lstate = L_SETUP;
					end
					default: if (is_cmd) {next_resp_pend, next_resp_ctrl} = {1'b1, C_FRMR | pf_f};
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lstate <= L_DOWN;
			{sabm_due, disc_due, resp_pend, resp_ctrl, i_sent, peer_busy, vs, vr} <= '0;
			{t_loaded, t_cnt, t_wr, deliv, d_idx, d_last, d_lbits} <= '0;
			{RX_DATA, RX_VALID, RX_LAST, RX_LAST_BITS} <= '0;
		end else begin
			lstate <= next_lstate;
			{sabm_due, disc_due} <= {next_sabm_due, next_disc_due};
			{resp_pend, resp_ctrl, i_sent} <= {next_resp_pend, next_resp_ctrl, next_i_sent};
			{peer_busy, vs, vr} <= {next_peer_busy, next_vs, next_vr};
			{t_loaded, t_cnt, t_wr} <= {next_t_loaded, next_t_cnt, next_t_wr};
			{deliv, d_idx, d_last, d_lbits} <= {next_deliv, next_d_idx, next_d_last, next_d_lbits};
			{RX_DATA, RX_VALID, RX_LAST, RX_LAST_BITS} <=
				{next_rx_data, next_rx_valid, next_rx_last, next_rx_lbits};
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	property p_flag_after_body;
		$rose(tstate == T_FLAG) |-> tsh == FLAG_OCTET;
	endproperty
	a_flag_after_body: assert property (p_flag_after_body) else $error("no closing flag");
	property p_idle_flags;
		(tick && !tstuff && tbit == 3'h7 && tstate == T_FLAG && !start) |=> tsh == FLAG_OCTET;
	endproperty
	a_idle_flags: assert property (p_idle_flags) else $error("idle fill is not a flag");
	property p_stuff;
		(tick && !tstuff && tstate == T_BODY && tsh[0] && tones == 3'h4) |=> tstuff;
	endproperty
	a_stuff: assert property (p_stuff) else $error("zero not armed");
	// The inserted zero waits for the next bit tick, however slow the line
	property p_stuff_zero;
		(tick && tstuff) |=> !txd && !tstuff;
	endproperty
	a_stuff_zero: assert property (p_stuff_zero) else $error("zero not inserted");
	property p_block_max;
		(tb_we && t_wr == 8'(MAX_BLOCK - 1)) |=> t_loaded && t_cnt == 8'(MAX_BLOCK);
	endproperty
	a_block_max: assert property (p_block_max) else $error("block not closed at limit");
	property p_sabm_ua;
		(frame_good && is_cmd && (r_ctrl & ~PF_MASK) == C_SABM)
			|=> resp_pend && (resp_ctrl & ~PF_MASK) == C_UA && lstate == L_UP;
	endproperty
	a_sabm_ua: assert property (p_sabm_ua) else $error("set-mode not acknowledged");
	property p_poll_final;
		(frame_good && is_cmd && r_ctrl[4]) |=> resp_pend && resp_ctrl[4];
	endproperty
	a_poll_final: assert property (p_poll_final) else $error("poll without final");
	property p_deliver_good;
		$rose(deliv) |-> $past(frame_good) && $past(is_cmd);
	endproperty
	a_deliver_good: assert property (p_deliver_good) else $error("delivery without good frame");
	property p_i_cmd_only;
		took_i |=> !t_ctrl[0] && tsh == peer_addr && tstate == T_BODY;
	endproperty
	a_i_cmd_only: assert property (p_i_cmd_only) else $error("bad information frame");
	property p_rnr_busy;
		(frame_good && is_cmd && !r_ctrl[0] && deliv && lstate == L_UP)
			|=> resp_pend && resp_ctrl[3:0] == S_RNR[3:0];
	endproperty
	a_rnr_busy: assert property (p_rnr_busy) else $error("busy not reported");
	property p_bit_rate;
		(tick && BIT_DIV == 16'h0003) |=> !tick ##1 !tick ##1 tick;
	endproperty
	a_bit_rate: assert property (p_bit_rate) else $error("bit period wrong");
	c_i_sent:   cover property (took_i);
	c_rx_good:  cover property (frame_good && is_cmd && !r_ctrl[0]);
	c_link_up:  cover property ($rose(lstate == L_UP));
	c_rx_last:  cover property (RX_VALID && RX_READY && RX_LAST);
endmodule
`default_nettype wire

// ---- verif/far_station.sv ----
// Far-end combined station model on the serial line
`default_nettype none
module far_station
	import lapb_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic txd,
	input  wire logic strobe,
	output var logic  rxd,
	output var logic  bit_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  info [MAX_BLOCK_OCTETS];
	logic [7:0]  gb [140];
	logic        q [$];
	logic [7:0]  sh = 8'h00;
	logic [15:0] rc;
	int          nf = 0;
	int          nb, k;
	initial begin
		rxd = 1'b1;
		bit_valid = 1'b0;
	end
	function automatic logic [15:0] nxt(input logic [15:0] c, input logic b);
		return (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
	endfunction
	task automatic put(input logic b);
		@(posedge ref_clk);
		rxd <= b;
		bit_valid <= 1'b1;
	endtask
	// op low reuses the last closing flag; a released line shows the inverse bit
	task automatic send(input logic [7:0] a, c, input int n, input logic op, rel, bad);
		logic [7:0]  f [$];
		logic [15:0] crc;
		int          o;
		f = {a, c};
		for (int i = 0; i < n; i++)
			f.push_back(info[i]);
		crc = CRC_INIT;
		foreach (f[i])
			for (int j = 0; j < 8; j++)
				crc = nxt(crc, f[i][j]);
		crc = ~crc ^ {15'h0000, bad};
		f.push_back(crc[7:0]);
		f.push_back(crc[15:8]);
		o = 0;
		for (int j = 0; j < 8 && op; j++)
			put(FLAG_OCTET[j]);
		foreach (f[i])
			for (int j = 0; j < 8; j++) begin
				put(f[i][j]);
				o = f[i][j] ? o + 1 : 0;
				if (o == 5) begin
					put(1'b0);
					o = 0;
				end
			end
		for (int j = 0; j < 8; j++)
			put(FLAG_OCTET[j]);
		if (rel) begin
			@(posedge ref_clk);
			bit_valid <= 1'b0;
			rxd <= ~rxd;
		end
	endtask
	// Strips stuffed zeros and counts only frames with a good residue
	always @(posedge ref_clk)
		if (strobe) begin
			sh = {txd, sh[7:1]};
			if (sh == FLAG_OCTET) begin
				nb = q.size() - 7;
				rc = CRC_INIT;
				for (int i = 0; i < nb; i++) begin
					rc = nxt(rc, q[i]);
					gb[i / 8][i % 8] = q[i];
				end
				if (nb >= MIN_FRAME_BITS && rc == CRC_RESIDUE)
					nf++;
				q = {};
				k = 0;
			end else if (k == 5 && !txd)
				k = 0;
			else begin
				q.push_back(txd);
				k = txd ? k + 1 : 0;
			end
		end
endmodule
`default_nettype wire

// ---- verif/lapb_link_framer_tb_top.sv ----
// Self-checking bench: the framer against a far-end station model
`default_nettype none
module lapb_link_framer_tb_top
	import lapb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Far-end address, control, info count, then the expected response control
	logic [31:0] rows [7] = '{32'hc03f0073, 32'hc0110011, 32'hc0000321, 32'hc0150031,
		32'hc0040029, 32'h80000087, 32'hc053001f};
	logic        clk = 1'b0, rst = 1'b1, cfg = 1'b0, open = 1'b0, close = 1'b0;
	logic        tx_valid = 1'b0, tx_last = 1'b0, rx_ready = 1'b1;
	logic [15:0] div = 16'h0001;
	logic [7:0]  laddr = 8'h00, paddr = 8'h00, tx_data = 8'h00, rx_data;
	logic [3:0]  rx_last_bits, lb;
	logic        link_up, tx_ready, txd, strobe, rxd, bvalid, rx_valid, rx_last;
	logic [7:0]  dq [$];
	int          bad_count = 0, tests_run = 0, cyc = 0, ls = 0, gap = 0, f0;
	always #10 clk = ~clk;
	lapb_link_framer lapb_link_framer_inst (.REF_CLK(clk), .RST(rst), .BIT_DIV(div),
		.USE_CFG_ADDR(cfg), .LOCAL_ADDR(laddr), .PEER_ADDR(paddr), .LINK_OPEN(open),
		.LINK_CLOSE(close), .LINK_UP(link_up), .TX_DATA(tx_data), .TX_VALID(tx_valid),
		.TX_LAST(tx_last), .TX_READY(tx_ready), .TXD(txd), .TX_BIT_STROBE(strobe),
		.RXD(rxd), .RX_BIT_VALID(bvalid), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_LAST(rx_last), .RX_LAST_BITS(rx_last_bits), .RX_READY(rx_ready));
	far_station far_station_inst (.ref_clk(clk), .txd(txd), .strobe(strobe), .rxd(rxd),
		.bit_valid(bvalid));
	always @(posedge clk) begin
		cyc++;
		if (strobe) begin
			gap = cyc - ls;
			ls = cyc;
		end
		if (rx_valid && rx_ready) begin
			dq.push_back(rx_data);
			if (rx_last)
				lb = rx_last_bits;
		end
	end
	task automatic chk(input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_for(input int want);
		for (int t = 0; t < 3000 && far_station_inst.nf < f0 + want; t++)
			@(posedge clk);
		chk(far_station_inst.nf, f0 + want);
	endtask
	initial begin
		#400000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		far_station_inst.info[0] = 8'hff;
		far_station_inst.info[1] = 8'h7e;
		far_station_inst.info[2] = 8'h3c;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 chk({txd, tx_ready, link_up}, 3'b110);
		repeat (50) @(posedge clk);
		chk(far_station_inst.q.size() < 8, 1);
		foreach (rows[i]) begin
			f0 = far_station_inst.nf;
			far_station_inst.send(rows[i][31:24], rows[i][23:16], rows[i][15:8], 1, 1, 0);
			wait_for(1);
			chk(far_station_inst.gb[0], DEF_LOCAL_ADDR);
			chk(far_station_inst.gb[1], rows[i][7:0]);
			chk(link_up, rows[i][23:16] != 8'h53);
		end
		chk({dq.size(), dq[0], dq[1], dq[2], lb}, {32'd3, 24'hff7e3c, 4'h8});
		f0 = far_station_inst.nf;
		far_station_inst.send(8'hc0, 8'h3f, 0, 1, 1, 1);
		repeat (500) @(posedge clk);
		chk({far_station_inst.nf, link_up}, {f0, 1'b0});
		far_station_inst.send(8'hc0, 8'h3f, 0, 1, 0, 0);
		far_station_inst.send(8'hc0, 8'h11, 0, 0, 1, 0);
		wait_for(2);
		chk({far_station_inst.gb[1], link_up}, {8'h11, 1'b1});
		// A stalled delivery must answer the next information frame with not-ready
		rx_ready <= 1'b0;
		f0 = far_station_inst.nf;
		far_station_inst.send(8'hc0, 8'h00, 2, 1, 1, 0);
		far_station_inst.send(8'hc0, 8'h02, 2, 1, 1, 0);
		wait_for(2);
		chk(far_station_inst.gb[1], 8'h25);
		rx_ready <= 1'b1;
		f0 = far_station_inst.nf;
		tx_valid <= 1'b1;
		tx_data <= 8'h81;
		@(posedge clk);
		tx_data <= 8'h7e;
		tx_last <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b0;
		tx_last <= 1'b0;
		#1 chk(tx_ready, 0);
		wait_for(1);
		chk({far_station_inst.gb[0], far_station_inst.gb[1], far_station_inst.gb[2],
			far_station_inst.gb[3], far_station_inst.nb}, {32'h8020817e, 32'd48});
		far_station_inst.send(8'h80, 8'h21, 0, 1, 1, 0);
		repeat (200) @(posedge clk);
		#1 chk(tx_ready, 1);
		f0 = far_station_inst.nf;
		@(posedge clk) close <= 1'b1;
		@(posedge clk) close <= 1'b0;
		wait_for(1);
		chk({far_station_inst.gb[0], far_station_inst.gb[1]}, 16'h8053);
		far_station_inst.send(8'h80, 8'h1f, 0, 1, 1, 0);
		repeat (200) @(posedge clk);
		chk(link_up, 0);
		f0 = far_station_inst.nf;
		cfg <= 1'b1;
		laddr <= 8'h3a;
		paddr <= 8'h5c;
		div <= 16'h0003;
		open <= 1'b1;
		@(posedge clk) open <= 1'b0;
		wait_for(1);
		chk({far_station_inst.gb[0], far_station_inst.gb[1], gap}, {16'h5c3f, 32'd3});
		report_and_stop();
	end
endmodule
`default_nettype wire
